// ===== core/edc_core.sv
// Purpose: register file and update-rate divider of the excitation DAC
// Assumes: sys_clk is the analog clock; one clock domain only
// Notes: AXI4-Lite slave; codes leave on each divider tick
//
// Local design decision: the AXI4-Lite interface to the registers.
`include "edc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module edc_core (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// register bus
	input wire edc_pkg::edc_axi_req_t axi_req,
	output edc_pkg::edc_axi_rsp_t axi_rsp,
	// analog side
	output edc_pkg::edc_analog_t analog
);
	import edc_pkg::*;

	// register storage
	logic [12:0] config_reg;
	logic [11:0] code_reg;
	logic [3:0] pwrbw_reg;
	logic [11:0] live_code;
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic tick;
	logic code_clipped;

	// bus state
	logic aw_held;
	logic w_held;
	logic [`EDC_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic aw_rdy;
	logic w_rdy;
	logic b_vld;
	logic [1:0] b_resp;
	logic ar_rdy;
	logic r_vld;
	logic [31:0] r_data;
	logic [1:0] r_resp;
	logic [31:0] cfg_merged;
	logic [31:0] code_merged;
	logic [31:0] pwrbw_merged;

	// byte-lane merge, used for every writable register
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// decoded read value; unmapped gives zero with an error answer
	function automatic logic [31:0] read_mux(input logic [`EDC_ADDR_W-1:0] a,
		input logic [12:0] cfg, input logic [11:0] cod,
		input logic [3:0] pb, input logic [11:0] lc, input logic clp);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			`EDC_OFS_CONFIG: v = {19'h0_0000, cfg};
			`EDC_OFS_CODE: v = {20'h0_0000, cod};
			`EDC_OFS_PWRBW: v = {28'h000_0000, pb};
			`EDC_OFS_STATUS: v = {19'h0_0000, clp, lc};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [`EDC_ADDR_W-1:0] a);
		return (a == `EDC_OFS_CONFIG) || (a == `EDC_OFS_CODE) ||
			(a == `EDC_OFS_PWRBW) || (a == `EDC_OFS_STATUS);
	endfunction

	assign do_write = aw_held && w_held && !b_vld;

	// one driver for the whole answer struct; every field is a flop
	assign axi_rsp = '{awready: aw_rdy, wready: w_rdy, bvalid: b_vld,
		bresp: b_resp, arready: ar_rdy, rvalid: r_vld, rdata: r_data,
		rresp: r_resp};

	// write address and data are taken in either order and held
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 16'h0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			aw_rdy <= 1'b0;
			w_rdy <= 1'b0;
			b_vld <= 1'b0;
			b_resp <= `EDC_RESP_OKAY;
		end else begin
			aw_rdy <= !aw_held && !aw_rdy && axi_req.awvalid;
			w_rdy <= !w_held && !w_rdy && axi_req.wvalid;
			if (aw_rdy && axi_req.awvalid) begin
				aw_held <= 1'b1;
				aw_addr <= axi_req.awaddr;
			end
			if (w_rdy && axi_req.wvalid) begin
				w_held <= 1'b1;
				w_data <= axi_req.wdata;
				w_strb <= axi_req.wstrb;
			end
			if (do_write) begin
				b_vld <= 1'b1;
				b_resp <= mapped(aw_addr) ? `EDC_RESP_OKAY :
					`EDC_RESP_SLVERR;
			end else if (b_vld && axi_req.bready) begin
				b_vld <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	// read channel: one read at a time, answer two edges after arvalid
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ar_rdy <= 1'b0;
			r_vld <= 1'b0;
			r_data <= 32'h0000_0000;
			r_resp <= `EDC_RESP_OKAY;
		end else begin
			ar_rdy <= !ar_rdy && !r_vld && axi_req.arvalid;
			if (ar_rdy && axi_req.arvalid) begin
				r_vld <= 1'b1;
				r_data <= read_mux(axi_req.araddr, config_reg,
					code_reg, pwrbw_reg, live_code, code_clipped);
				r_resp <= mapped(axi_req.araddr) ? `EDC_RESP_OKAY :
					`EDC_RESP_SLVERR;
			end else if (r_vld && axi_req.rready) begin
				r_vld <= 1'b0;
			end
		end
	end

	// merged words; a function result cannot be part-selected directly
	assign cfg_merged = merge({19'h0_0000, config_reg}, w_data,
		w_strb);
	assign code_merged = merge({20'h0_0000, code_reg}, w_data,
		w_strb);
	assign pwrbw_merged = merge({28'h000_0000, pwrbw_reg}, w_data,
		w_strb);

	// configuration: reserved bits masked so they never store
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			config_reg <= `EDC_CONFIG_RESET;
		end else if (do_write && aw_addr == `EDC_OFS_CONFIG) begin
			config_reg <= cfg_merged[12:0] & `EDC_CONFIG_MASK;
		end
	end

	// dac code register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			code_reg <= `EDC_CODE_RESET;
		end else if (do_write && aw_addr == `EDC_OFS_CODE) begin
			code_reg <= code_merged[11:0];
		end
	end

	// power and bandwidth register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pwrbw_reg <= `EDC_PWRBW_RESET;
		end else if (do_write && aw_addr == `EDC_OFS_PWRBW) begin
			pwrbw_reg <= pwrbw_merged[3:0] & `EDC_PWRBW_MASK;
		end
	end

	// update divider; sys_clk stands for whichever analog clock runs
	always_comb begin
		if (div_cnt <= 8'h01) begin
			next_div_cnt = config_reg[`EDC_RATE_MSB:`EDC_RATE_LSB];
		end else begin
			next_div_cnt = div_cnt - 8'h01;
		end
	end
	assign tick = (div_cnt <= 8'h01);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// load a clamped code each tick; clamp keeps code in valid span
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			live_code <= `EDC_CODE_RESET;
			code_clipped <= 1'b0;
		end else if (tick) begin
			if (code_reg < `EDC_CODE_MIN) begin
				live_code <= `EDC_CODE_MIN;
				code_clipped <= 1'b1;
			end else if (code_reg > `EDC_CODE_MAX) begin
				live_code <= `EDC_CODE_MAX;
				code_clipped <= 1'b1;
			end else begin
				live_code <= code_reg;
				code_clipped <= 1'b0;
			end
		end
	end

	// analog outputs, all registered
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			analog.code <= `EDC_CODE_RESET;
			analog.dac_update <= 1'b0;
			analog.gain_quarter <= 1'b0;
			analog.atten_en <= 1'b0;
			analog.high_power <= 1'b0;
			analog.filt <= edc_filt_off;
		end else begin
			analog.code <= live_code;
			analog.dac_update <= tick;
			analog.gain_quarter <= config_reg[`EDC_BIT_GAIN];
			analog.atten_en <= config_reg[`EDC_BIT_ATTEN];
			analog.high_power <= pwrbw_reg[`EDC_BIT_HIPWR];
			analog.filt <= edc_filt_t'(
				pwrbw_reg[`EDC_FILT_MSB:`EDC_FILT_LSB]);
		end
	end

endmodule
`default_nettype wire

// ===== inc/edc_consts.svh
// Purpose: constants for the excitation DAC control block
// Assumes: 32-bit AXI4-Lite register bus, byte addressing
// Notes: offsets are byte addresses, low 16 bits decoded
`ifndef EDC_CONSTS_SVH
`define EDC_CONSTS_SVH

`define EDC_ADDR_W 16
`define EDC_OFS_CONFIG 16'h2010
`define EDC_OFS_CODE 16'h2048
`define EDC_OFS_PWRBW 16'h2050
`define EDC_OFS_STATUS 16'h2054

`define EDC_CONFIG_RESET 13'h001e
`define EDC_CONFIG_MASK 13'h11ff
`define EDC_CODE_RESET 12'h800
`define EDC_CODE_MIN 12'h200
`define EDC_CODE_MAX 12'he00
`define EDC_PWRBW_RESET 4'h0
`define EDC_PWRBW_MASK 4'hd

`define EDC_BIT_ATTEN 0
`define EDC_RATE_LSB 1
`define EDC_RATE_MSB 8
`define EDC_BIT_GAIN 12
`define EDC_BIT_HIPWR 0
`define EDC_FILT_LSB 2
`define EDC_FILT_MSB 3

`define EDC_RESP_OKAY 2'b00
`define EDC_RESP_SLVERR 2'b10

`endif

// ===== inc/edc_pkg.sv
// Purpose: types for the excitation DAC control block
// Assumes: constants come from edc_consts.svh
// Notes: axi channel groups travel as packed structs
`include "edc_consts.svh"

package edc_pkg;

	// write and read requests from the master, with bready and rready
	typedef struct packed {
		logic awvalid;
		logic [`EDC_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`EDC_ADDR_W-1:0] araddr;
		logic rready;
	} edc_axi_req_t;

	// answers back to the master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} edc_axi_rsp_t;

	// filter cutoff choices
	typedef enum logic [1:0] {
		edc_filt_off,
		edc_filt_50k,
		edc_filt_100k,
		edc_filt_250k
	} edc_filt_t;

	// settings handed to the analog side
	typedef struct packed {
		logic [11:0] code;
		logic dac_update;
		logic gain_quarter;
		logic atten_en;
		logic high_power;
		edc_filt_t filt;
	} edc_analog_t;

endpackage

// ===== testbench/edc_core_properties.sv
// Purpose: port checks for edc_core
// Assumes: one clock, async active-low reset
// Notes: bound onto every edc_core instance
`timescale 1ns/1ps
`default_nettype none
module edc_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// bus and analog side
	input wire edc_pkg::edc_axi_req_t axi_req,
	input wire edc_pkg::edc_axi_rsp_t axi_rsp,
	input wire edc_pkg::edc_analog_t analog
);
	import edc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// code seen by the dac stays in span and moves only after a tick
	a_code_clamp: assert property (analog.code >= 12'h200 &&
		analog.code <= 12'he00) else $error("code out of span");
	a_code_moves: assert property ($changed(analog.code) |->
		$past(analog.dac_update) || $past(analog.dac_update, 2))
		else $error("code moved without tick");
	// bus handshakes: ready pulses, answers at fixed distance
	a_aw_pulse: assert property (axi_rsp.awready |=> !axi_rsp.awready)
		else $error("awready held");
	a_ar_pulse: assert property (axi_rsp.arready |=> !axi_rsp.arready)
		else $error("arready held");
	a_ar_answer: assert property (axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("late read answer");
	a_wr_answer: assert property (axi_rsp.awready && axi_rsp.wready
		|-> ##2 axi_rsp.bvalid) else $error("late write answer");
	a_b_drop: assert property (axi_rsp.bvalid && axi_req.bready
		|=> !axi_rsp.bvalid) else $error("bvalid stuck");
	a_r_drop: assert property (axi_rsp.rvalid && axi_req.rready
		|=> !axi_rsp.rvalid) else $error("rvalid stuck");
	// main scenarios reached
	c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp[1]);
	c_tick: cover property (analog.dac_update);
	c_read: cover property (axi_rsp.rvalid);
endmodule
bind edc_core edc_props u_props (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.axi_req(axi_req),
	.axi_rsp(axi_rsp),
	.analog(analog)
);
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for edc_core
// Assumes: bus tasks act as an AXI4-Lite master
// Notes: reset values first, then table rows, tick, clamp, filter, reset
`include "edc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import edc_pkg::*;
	typedef struct {
		logic [15:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic [1:0] r;
	} edc_row_t;
	logic sys_clk;
	logic rstn;
	edc_axi_req_t axi_req;
	edc_axi_rsp_t axi_rsp;
	edc_analog_t analog;
	int bad_count;
	int comparisons;
	int cyc;
	logic [31:0] q;
	logic [1:0] r;
	// address, write data, read back, response; last is unmapped
	edc_row_t rows [4] = '{
		'{`EDC_OFS_CONFIG, 32'hffff_ffff, 32'h0000_11ff, 2'b00},
		'{`EDC_OFS_CODE, 32'hffff_fabc, 32'h0000_0abc, 2'b00},
		'{`EDC_OFS_PWRBW, 32'h0000_000f, 32'h0000_000d, 2'b00},
		'{16'h2000, 32'h1234_5678, 32'h0000_0000, `EDC_RESP_SLVERR}};
	edc_core uut (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.axi_req(axi_req),
		.axi_rsp(axi_rsp),
		.analog(analog)
	);
	// 100 ns period
	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// cut a hang short; whole run needs well under this
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	// each channel released at its own ready; bready held till bvalid
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
		end while (!axi_rsp.bvalid);
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
		end while (!axi_rsp.rvalid);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask
	// two ticks first, since the old count may still be running
	task automatic gap(input logic [31:0] cfg, input logic [31:0] n);
		logic [31:0] c;
		wr(`EDC_OFS_CONFIG, cfg);
		repeat (2) begin
			@(posedge sys_clk);
			while (!analog.dac_update) @(posedge sys_clk);
		end
		c = 0;
		do begin
			@(posedge sys_clk);
			c++;
		end while (!analog.dac_update);
		chk(c, n);
	endtask
	task automatic clamp(input logic [31:0] d, input logic [11:0] e);
		wr(`EDC_OFS_CODE, d);
		repeat (4) @(posedge sys_clk);
		chk({20'h0, analog.code}, {20'h0, e});
		rd(`EDC_OFS_STATUS, q);
		chk(q, {19'h0, (d[11:0] != e), e});
	endtask
	// main sequence
	initial begin
		rstn = 0;
		axi_req = '0;
		repeat (20) @(posedge sys_clk);
		rstn <= 1;
		rd(`EDC_OFS_CONFIG, q);
		chk(q, 32'h0000_001e);
		rd(`EDC_OFS_CODE, q);
		chk(q, 32'h0000_0800);
		chk({20'h0, analog.code}, 32'h0000_0800);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk({30'h0, r}, {30'h0, rows[i].r});
			rd(rows[i].a, q);
			chk(q, rows[i].q);
			chk({30'h0, r}, {30'h0, rows[i].r});
		end
		chk({30'h0, analog.gain_quarter, analog.atten_en}, 32'h3);
		gap(32'h0000_0006, 32'h3);
		gap(32'h0000_0036, 32'h0000_001b);
		gap(32'h0000_000e, 32'h0000_0007);
		chk({30'h0, analog.gain_quarter, analog.atten_en}, 32'h0);
		wr(`EDC_OFS_CONFIG, 32'h0000_1000);
		@(posedge sys_clk);
		chk({30'h0, analog.gain_quarter, analog.atten_en}, 32'h2);
		gap(32'h0000_0000, 32'h1);
		// no adc, window, tia or buffer setting here
		// no offset trim is written while gain bits change
		clamp(32'h0000_0100, 12'h200);
		clamp(32'h0000_0f00, 12'he00);
		clamp(32'h0000_0abc, 12'habc);
		for (int i = 0; i < 4; i++) begin
			wr(`EDC_OFS_PWRBW, 32'(i * 5));
			repeat (3) @(posedge sys_clk);
			chk({29'h0, analog.filt, analog.high_power},
				32'(i * 2 + i % 2));
		end
		rstn <= 0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1;
		rd(`EDC_OFS_CONFIG, q);
		chk(q, 32'h0000_001e);
		finish_test();
	end
endmodule
`default_nettype wire
